// file: design/perf_monitor_pkg.sv
// shared constants and carriers for the stream traffic monitor
package perf_monitor_pkg;

  localparam int DATA_W = 128;
  localparam int BEAT_BYTES = DATA_W / 8;
  localparam int COUNT_W = 32;
  localparam int INDEX_W = 2;
  localparam int CLK_MHZ = 25;
  // snapshot interval in milliseconds, cycles derived from the clock rate
  localparam int INTERVAL_MS = 1000;
  localparam int INTERVAL_CYCLES = INTERVAL_MS * CLK_MHZ * 1000;
  localparam int DISCONTINUE_BIT = 3;
  localparam int TUSER_W = 22;

  // header field positions in the first 128-bit beat
  localparam int HDR_FMT_MSB = 30;
  localparam int HDR_FMT_LSB = 29;
  localparam int HDR_TYPE_MSB = 28;
  localparam int HDR_TYPE_LSB = 24;
  localparam int HDR_LEN_MSB = 9;
  localparam int HDR_LEN_LSB = 0;
  localparam int LEN_W = 10;

  localparam logic [4:0] TYPE_MEM = 5'h00;
  localparam logic [4:0] TYPE_CPL = 5'h0A;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 2'h0;

  typedef struct packed {
    logic [DATA_W-1:0] tdata;
    logic tlast;
    logic tvalid;
    logic tready;
    logic discontinue;
  } stream_tap_type;

  typedef struct packed {
    logic [COUNT_W-1:0] tx_bytes;
    logic [COUNT_W-1:0] rx_bytes;
    logic [COUNT_W-1:0] tx_payload;
    logic [COUNT_W-1:0] rx_payload;
  } counts_type;

endpackage : perf_monitor_pkg

// file: design/pcie_stream_perf_monitor.sv
// passive byte counters on both pcie streams with periodic snapshots
//
// Contract
// - observe both 128-bit streams, one clock
// - beat counts only when valid and ready
// - outbound raw count adds every transmit beat
// - inbound raw count adds every receive beat
// - outbound payload: memory writes and data completions
// - inbound payload: memory writes and data completions
// - packet start is first beat after tlast
// - four reported counts are 32 bits
// - counts in words, low bits hold index
// - index steps 00,01,10,11 each second
// - timer expiry loads new counts into outputs
// - pure user payload is not computed
// - snapshots exposed for periodic software reads
`timescale 1ns/10ps

module pcie_stream_perf_monitor
  import perf_monitor_pkg::*;
#(
  parameter int INTERVAL_LEN = INTERVAL_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [DATA_W-1:0] s_axis_tx_tdata,
  input wire logic s_axis_tx_tlast,
  input wire logic s_axis_tx_tvalid,
  input wire logic [TUSER_W-1:0] s_axis_tx_tuser,
  input wire logic s_axis_tx_tready,
  input wire logic [DATA_W-1:0] m_axis_rx_tdata,
  input wire logic m_axis_rx_tlast,
  input wire logic m_axis_rx_tvalid,
  input wire logic m_axis_rx_tready,
  output logic [COUNT_W-1:0] tx_byte_count,
  output logic [COUNT_W-1:0] rx_byte_count,
  output logic [COUNT_W-1:0] tx_payload_count,
  output logic [COUNT_W-1:0] rx_payload_count
);

  ////////////////////////////////////////////////////////////////////////////
  // header decoding, shared by both directions

  // payload bytes of a tlp whose first beat is hdr; zero if not counted
  function automatic logic [COUNT_W-1:0] payload_bytes(
    input logic [DATA_W-1:0] hdr,
    input logic need_data
  );
    logic [1:0] fmt;
    logic [4:0] typ;
    logic [LEN_W-1:0] len;
    logic has_data;
    logic [LEN_W:0] dw;
    fmt = hdr[HDR_FMT_MSB:HDR_FMT_LSB];
    typ = hdr[HDR_TYPE_MSB:HDR_TYPE_LSB];
    len = hdr[HDR_LEN_MSB:HDR_LEN_LSB];
    has_data = fmt[1];
    // a zero length field encodes 1024 doublewords
    dw = (len == '0) ? {1'b1, {LEN_W{1'b0}}} : {1'b0, len};
    payload_bytes = COUNT_RESET;
    if (has_data && (typ == TYPE_MEM || (typ == TYPE_CPL && need_data))) begin
      payload_bytes = COUNT_W'({dw, 2'b00});
    end
  endfunction : payload_bytes

  ////////////////////////////////////////////////////////////////////////////
  // stream taps

  stream_tap_type tap [2];
  logic [1:0] beat;
  logic [1:0] sop;
  logic [1:0] in_pkt_q;
  logic [1:0] in_pkt_d;
  logic [COUNT_W-1:0] pay_add [2];

  assign tap[0] = '{tdata: s_axis_tx_tdata, tlast: s_axis_tx_tlast,
                    tvalid: s_axis_tx_tvalid, tready: s_axis_tx_tready,
                    discontinue: s_axis_tx_tuser[DISCONTINUE_BIT]};
  assign tap[1] = '{tdata: m_axis_rx_tdata, tlast: m_axis_rx_tlast,
                    tvalid: m_axis_rx_tvalid, tready: m_axis_rx_tready,
                    discontinue: 1'b0};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dir
      // transfer only with both handshake lines
      assign beat[g] = tap[g].tvalid && tap[g].tready;
      // start is the first beat outside a packet
      assign sop[g] = beat[g] && !in_pkt_q[g];
      // decode header on the first beat
      // tx and rx both take only completions with data
      assign pay_add[g] = sop[g] ? payload_bytes(tap[g].tdata, 1'b1)
                                 : COUNT_RESET;
      // tlast only taken on an accepted beat
      // a discontinue ends the packet with tlast
      assign in_pkt_d[g] = beat[g] ? !(tap[g].tlast || tap[g].discontinue)
                                   : in_pkt_q[g];
    end
  endgenerate

  // one process owns both packet-state bits, no split drivers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_pkt_q <= 2'h0;
    end else begin
      in_pkt_q <= in_pkt_d;
    end
  end

  a_pkt_end: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axis_tx_tvalid && s_axis_tx_tready && s_axis_tx_tlast |=> !in_pkt_q[0])
    else $error("packet did not end on tlast");

  a_tlast_ignored: assert property (
    @(posedge mclk) disable iff (!nrst)
    !beat[1] |=> in_pkt_q[1] == $past(in_pkt_q[1]))
    else $error("packet state moved without a beat");

  a_pkt_start: assert property (
    @(posedge mclk) disable iff (!nrst)
    sop[1] && !m_axis_rx_tlast |=> in_pkt_q[1])
    else $error("packet did not open on its first beat");

  a_disc_end: assert property (
    @(posedge mclk) disable iff (!nrst)
    beat[0] && s_axis_tx_tuser[DISCONTINUE_BIT] |=> !in_pkt_q[0])
    else $error("discontinue did not end the packet");

  ////////////////////////////////////////////////////////////////////////////
  // interval timer and sample index

  logic [31:0] timer_q;
  logic tick;
  logic [INDEX_W-1:0] index_q;

  assign tick = (timer_q == 32'(INTERVAL_LEN - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_q <= COUNT_RESET;
    end else begin
      timer_q <= tick ? COUNT_RESET : timer_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      index_q <= INDEX_RESET;
    end else if (tick) begin
      index_q <= index_q + 2'h1;
    end
  end

  a_index_step: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick |=> index_q == $past(index_q) + 2'h1)
    else $error("sample index did not step");

  a_timer_wrap: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick |=> timer_q == 32'h0)
    else $error("interval timer did not restart");

  a_timer_step: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick |=> timer_q == $past(timer_q) + 32'h1)
    else $error("interval timer did not advance");

  ////////////////////////////////////////////////////////////////////////////
  // accumulators and snapshots

  counts_type acc_q;
  counts_type acc_d;
  counts_type add;
  counts_type snap_q;
  counts_type snap_d;
  logic [COUNT_W-1:0] beat_bytes_tx;
  logic [COUNT_W-1:0] beat_bytes_rx;

  // every accepted beat adds its full width
  assign beat_bytes_tx = beat[0] ? COUNT_W'(BEAT_BYTES) : COUNT_RESET;
  assign beat_bytes_rx = beat[1] ? COUNT_W'(BEAT_BYTES) : COUNT_RESET;
  // only tlp payload, never user payload
  assign add = '{tx_bytes: beat_bytes_tx, rx_bytes: beat_bytes_rx,
                 tx_payload: pay_add[0], rx_payload: pay_add[1]};

  // restart from this cycle's bytes on the snapshot
  assign acc_d = tick ? add
                      : '{tx_bytes: acc_q.tx_bytes + add.tx_bytes,
                          rx_bytes: acc_q.rx_bytes + add.rx_bytes,
                          tx_payload: acc_q.tx_payload + add.tx_payload,
                          rx_payload: acc_q.rx_payload + add.rx_payload};

  // word resolution, low bits carry the new index
  assign snap_d = '{
    tx_bytes: {acc_q.tx_bytes[COUNT_W-1:INDEX_W], index_q + 2'h1},
    rx_bytes: {acc_q.rx_bytes[COUNT_W-1:INDEX_W], index_q + 2'h1},
    tx_payload: {acc_q.tx_payload[COUNT_W-1:INDEX_W], index_q + 2'h1},
    rx_payload: {acc_q.rx_payload[COUNT_W-1:INDEX_W], index_q + 2'h1}};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  a_raw_tx_add: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick && beat[0] |=> acc_q.tx_bytes == $past(acc_q.tx_bytes) + 32'h10)
    else $error("transmit beat not counted");

  a_raw_rx_add: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick && beat[1] |=> acc_q.rx_bytes == $past(acc_q.rx_bytes) + 32'h10)
    else $error("receive beat not counted");

  a_raw_rx_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick && !(m_axis_rx_tvalid && m_axis_rx_tready)
      |=> $stable(acc_q.rx_bytes))
    else $error("receive bytes counted without transfer");

  a_raw_tx_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick && !(s_axis_tx_tvalid && s_axis_tx_tready)
      |=> $stable(acc_q.tx_bytes))
    else $error("transmit bytes counted without transfer");

  a_acc_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick && !beat[0] |=> acc_q.tx_bytes == 32'h0)
    else $error("accumulator not cleared at snapshot");

  a_acc_clear_rx: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick && !beat[1] |=> acc_q.rx_bytes == 32'h0)
    else $error("receive accumulator not cleared at snapshot");

  a_payload_mid: assert property (
    @(posedge mclk) disable iff (!nrst)
    in_pkt_q[1] && !tick |=> $stable(acc_q.rx_payload))
    else $error("payload counted past first beat");

  a_tx_no_data: assert property (
    @(posedge mclk) disable iff (!nrst)
    sop[0] && !s_axis_tx_tdata[HDR_FMT_MSB] && !tick
      |=> $stable(acc_q.tx_payload))
    else $error("transmit tlp without data counted");

  a_rx_no_data: assert property (
    @(posedge mclk) disable iff (!nrst)
    sop[1] && !m_axis_rx_tdata[HDR_FMT_MSB] && !tick
      |=> $stable(acc_q.rx_payload))
    else $error("receive tlp without data counted");

  // snapshot replaced only on timer expiry
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snap_q <= '0;
    end else if (tick) begin
      snap_q <= snap_d;
    end
  end

  assign tx_byte_count = snap_q.tx_bytes;
  assign rx_byte_count = snap_q.rx_bytes;
  assign tx_payload_count = snap_q.tx_payload;
  assign rx_payload_count = snap_q.rx_payload;

  sequence s_expiry;
    tick;
  endsequence

  sequence s_loaded;
    ##1 (tx_byte_count[1:0] == index_q);
  endsequence

  a_index_in_snapshot: assert property (
    @(posedge mclk) disable iff (!nrst) s_expiry |-> s_loaded)
    else $error("snapshot index does not match sample index");

  a_snapshot_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !tick |=> $stable(rx_payload_count) && $stable(tx_byte_count))
    else $error("snapshot changed without timer expiry");

  sequence s_raw_snapped;
    ##1 (tx_byte_count[COUNT_W-1:INDEX_W] ==
         $past(acc_q.tx_bytes[COUNT_W-1:INDEX_W]));
  endsequence

  sequence s_pay_snapped;
    ##1 (rx_payload_count[COUNT_W-1:INDEX_W] ==
         $past(acc_q.rx_payload[COUNT_W-1:INDEX_W]));
  endsequence

  a_snap_load: assert property (
    @(posedge mclk) disable iff (!nrst) s_expiry |-> s_raw_snapped)
    else $error("raw count not loaded at timer expiry");

  a_pay_load: assert property (
    @(posedge mclk) disable iff (!nrst) s_expiry |-> s_pay_snapped)
    else $error("payload count not loaded at timer expiry");

  a_word_index: assert property (
    @(posedge mclk) disable iff (!nrst)
    tick |=> rx_byte_count[1:0] == tx_payload_count[1:0])
    else $error("index bits differ across counts");

endmodule : pcie_stream_perf_monitor

// file: dv/stream_party_model.sv
// far-side model: source and sink of one monitored stream
`timescale 1ns/10ps

module stream_party_model
  import perf_monitor_pkg::*;
(
  input wire logic mclk,
  output stream_tap_type tap
);

  // body beats look like a header so a late decode would count twice
  localparam logic [31:0] DECOY = 32'h4000_0005;

  initial tap = '0;

  task automatic send(input logic [31:0] hdr, input int n, input bit slow,
                      input bit disc);
    logic [DATA_W-1:0] d;
    for (int k = 0; k < n; k++) begin
      d = (k == 0) ? {96'h0, hdr} : {4{DECOY}};
      @(posedge mclk);
      tap <= '{tdata: d, tlast: k == n - 1, tvalid: 1'b1, tready: !slow,
               discontinue: disc && k == n - 1};
      if (slow) begin
        @(posedge mclk);
        tap.tready <= 1'b1;
      end
      if (slow || k == n - 1) begin
        @(posedge mclk);
        tap <= '{tdata: ~d, tlast: k != n - 1, tvalid: 1'b0, tready: 1'b1,
                 discontinue: 1'b0};
      end
    end
  endtask : send

endmodule : stream_party_model

// file: dv/pcie_stream_perf_monitor_tb.sv
// self-checking bench for the stream traffic monitor
`timescale 1ns/10ps

module pcie_stream_perf_monitor_tb import perf_monitor_pkg::*;;

  // short interval keeps the run small
  localparam int ILEN = 40;
  logic mclk;
  logic nrst;
  stream_tap_type tx_tap;
  stream_tap_type rx_tap;
  logic [TUSER_W-1:0] tx_tuser;
  logic [COUNT_W-1:0] tx_byte_count;
  logic [COUNT_W-1:0] rx_byte_count;
  logic [COUNT_W-1:0] tx_payload_count;
  logic [COUNT_W-1:0] rx_payload_count;
  logic [1:0] exp_idx;
  int n_errors;
  int tests_run;

  assign tx_tuser = TUSER_W'(tx_tap.discontinue) << DISCONTINUE_BIT;

  pcie_stream_perf_monitor #(.INTERVAL_LEN(ILEN)) i_pcie_stream_perf_monitor (
    .mclk(mclk),
    .nrst(nrst),
    .s_axis_tx_tdata(tx_tap.tdata),
    .s_axis_tx_tlast(tx_tap.tlast),
    .s_axis_tx_tvalid(tx_tap.tvalid),
    .s_axis_tx_tuser(tx_tuser),
    .s_axis_tx_tready(tx_tap.tready),
    .m_axis_rx_tdata(rx_tap.tdata),
    .m_axis_rx_tlast(rx_tap.tlast),
    .m_axis_rx_tvalid(rx_tap.tvalid),
    .m_axis_rx_tready(rx_tap.tready),
    .tx_byte_count(tx_byte_count),
    .rx_byte_count(rx_byte_count),
    .tx_payload_count(tx_payload_count),
    .rx_payload_count(rx_payload_count)
  );

  stream_party_model u_tx_party (.mclk(mclk), .tap(tx_tap));
  stream_party_model u_rx_party (.mclk(mclk), .tap(rx_tap));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] hdr(input logic [1:0] fmt,
                                      input logic [4:0] typ,
                                      input logic [9:0] len);
    return {1'b0, fmt, typ, 14'h0, len};
  endfunction : hdr

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_all(input logic [31:0] tb_e, rb_e, tp_e, rp_e);
    chk("tx_byte_count", tb_e | {30'h0, exp_idx}, tx_byte_count);
    chk("rx_byte_count", rb_e | {30'h0, exp_idx}, rx_byte_count);
    chk("tx_payload_count", tp_e | {30'h0, exp_idx}, tx_payload_count);
    chk("rx_payload_count", rp_e | {30'h0, exp_idx}, rx_payload_count);
  endtask : chk_all

  // bounded wait for the next snapshot, sampled between edges
  task automatic wait_tick();
    logic [1:0] prev;
    prev = tx_byte_count[1:0];
    for (int i = 0; i <= 2 * ILEN; i++) begin
      @(negedge mclk);
      if (tx_byte_count[1:0] !== prev) begin
        exp_idx = exp_idx + 2'h1;
        chk("index", {30'h0, exp_idx}, {30'h0, tx_byte_count[1:0]});
        return;
      end
    end
    n_errors++;
    give_verdict();
  endtask : wait_tick

  ////////////////////////////////////////////////////////////////////////////
  task automatic mixed_traffic();
    fork
      begin
        u_tx_party.send(hdr(2'h2, TYPE_MEM, 10'h004), 2, 1'b1, 1'b0);
        u_tx_party.send(hdr(2'h2, TYPE_CPL, 10'h002), 2, 1'b1, 1'b1);
        u_tx_party.send(hdr(2'h0, TYPE_CPL, 10'h003), 1, 1'b1, 1'b0);
      end
      begin
        u_rx_party.send(hdr(2'h0, TYPE_MEM, 10'h008), 1, 1'b1, 1'b0);
        u_rx_party.send(hdr(2'h2, TYPE_CPL, 10'h001), 2, 1'b1, 1'b0);
        u_rx_party.send(hdr(2'h3, TYPE_MEM, 10'h000), 1, 1'b1, 1'b0);
      end
    join
    wait_tick();
    chk_all(32'h0000_0050, 32'h0000_0040,
            32'h0000_0018, 32'h0000_1004);
  endtask : mixed_traffic

  task automatic idle_period();
    wait_tick();
    chk_all(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
  endtask : idle_period

  task automatic prompt_traffic();
    fork
      for (int p = 0; p < 3; p++) begin
        u_tx_party.send(hdr(2'h2, TYPE_MEM, 10'h001), 1, 1'b0, 1'b0);
      end
      u_rx_party.send(hdr(2'h2, TYPE_MEM, 10'h002), 3, 1'b0, 1'b0);
    join
    wait_tick();
    chk_all(32'h0000_0030, 32'h0000_0030,
            32'h0000_000C, 32'h0000_0008);
  endtask : prompt_traffic

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    nrst = 1'b0;
    exp_idx = 2'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    chk_all(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    wait_tick();
    mixed_traffic();
    idle_period();
    prompt_traffic();
    // index has wrapped to 00, next one must read 01
    idle_period();
    give_verdict();
  end

endmodule : pcie_stream_perf_monitor_tb
